// File: hdl/ppmc_top.sv
`timescale 1ns/1ps
`include "ppmc_map.svh"

module ppmc_top #(
  parameter int unsigned N_REQ = `PPMC_N_REQ,
  parameter int unsigned N_ACK = `PPMC_N_ACK,
  parameter int unsigned N_PD  = `PPMC_N_PD,
  parameter int unsigned N_UVD = `PPMC_N_UVD
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        power_good_i,
  input  wire logic        io_uv_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic        enable_pin_i,
  input  wire logic        temp_uv_i,
  input  wire logic [1:0]  pcs_receive_valid_i,
  input  wire logic [1:0]  transmit_enable_pin_i,
  input  wire logic [1:0]  sleep_code_seen_i,
  input  wire logic [1:0]  sleep_signalling_active_i,
  input  wire logic [1:0]  wake_request_code_i,
  input  wire logic [1:0]  peer_confirm_i,
  input  wire logic [1:0]  channel_active_i,
  input  wire logic [1:0]  wake_event_flag_i,
  input  wire logic [1:0]  remote_activity_i,
  output logic      [1:0]  rx_force_low_o,
  output logic      [1:0]  mii_drive_en_o,
  output logic      [1:0]  pcs_enable_o,
  output logic      [1:0]  activity_detect_en_o,
  output logic      [1:0]  sleep_request_code_o,
  output logic             regulator_inhibit_out_o,
  output logic             osc_enable_o,
  output logic             device_sleep_o
);

  // Pin and supply inputs pass two flip-flops before use.
  localparam int NS = 5 + 9 * 2;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  wire  [NS-1:0] raw_in = {power_good_i, io_uv_i, reset_pin_n_i,
    enable_pin_i, temp_uv_i, pcs_receive_valid_i, transmit_enable_pin_i,
    sleep_code_seen_i, sleep_signalling_active_i, wake_request_code_i,
    peer_confirm_i, channel_active_i, wake_event_flag_i, remote_activity_i};

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= raw_in;
      s2_q <= s1_q;
    end
  end

  wire       pwr_ok  = s2_q[22];
  wire       io_uv   = s2_q[21];
  wire       rst_pin = ~s2_q[20];
  wire       en_pin  = s2_q[19];
  wire       tmp_uv  = s2_q[18];
  wire [1:0] rxdv    = s2_q[17:16];
  wire [1:0] transmit_enable_pin    = s2_q[15:14];
  wire [1:0] lps_rx  = s2_q[13:12];
  wire [1:0] lps_act = s2_q[11:10];
  wire [1:0] wur_rx  = s2_q[9:8];
  wire [1:0] confirm = s2_q[7:6];
  wire [1:0] chan    = s2_q[5:4];
  wire [1:0] wake_ev = s2_q[3:2];
  wire [1:0] rem_act = s2_q[1:0];

  // APB register file.
  logic [4:0] ctrl_q [2];
  logic [4:0] devcfg_q;
  logic [1:0] abort_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  ppmc_pkg::ppmc_mode_t mode_q [2];

  wire acc     = psel_i & penable_i & ~pready_q;
  // Writes land at the edge that completes the transfer, with pready high.
  wire fin     = psel_i & penable_i & pready_q;
  wire wr      = fin & pwrite_i;
  wire hit_c0  = paddr_i == `PPMC_CTRL0_OFF;
  wire hit_c1  = paddr_i == `PPMC_CTRL1_OFF;
  wire hit_m0  = paddr_i == `PPMC_CMD0_OFF;
  wire hit_m1  = paddr_i == `PPMC_CMD1_OFF;
  wire hit_st  = paddr_i == `PPMC_STAT_OFF;
  wire hit_fl  = paddr_i == `PPMC_FLAG_OFF;
  wire hit_dc  = paddr_i == `PPMC_DEVCFG_OFF;
  wire any_sl  = (mode_q[0] == ppmc_pkg::PPMC_SLEEP) |
                 (mode_q[1] == ppmc_pkg::PPMC_SLEEP);
  wire known   = hit_c0 | hit_c1 | hit_m0 | hit_m1 | hit_st | hit_fl | hit_dc;
  // In Sleep only status reads and command reads or writes pass, and IO supply is needed.
  wire sl_ok   = ~any_sl | ((hit_st & ~pwrite_i) | hit_m0 | hit_m1) & ~io_uv;
  wire err     = ~known | ~sl_ok;
  wire [1:0] cmd_wr = {wr & hit_m1 & sl_ok, wr & hit_m0 & sl_ok};
  wire [3:0] cmd    = pwdata_i[3:0];
  wire [31:0] rd_mux =
      hit_c0 ? {27'h0, ctrl_q[0]} :
      hit_c1 ? {27'h0, ctrl_q[1]} :
      hit_st ? {26'h0, mode_q[1], mode_q[0]} :
      hit_fl ? {30'h0, abort_q} :
      hit_dc ? {27'h0, devcfg_q} : 32'h0;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      ctrl_q[0] <= `PPMC_CTRL_RST;
      ctrl_q[1] <= `PPMC_CTRL_RST;
      devcfg_q  <= `PPMC_DEVCFG_RST;
    end
    else
    begin
      pready_q  <= acc;
      pslverr_q <= acc & err;
      prdata_q  <= (acc & ~pwrite_i & ~err) ? rd_mux : 32'h0;
      if (wr & hit_c0 & ~err)
        ctrl_q[0] <= pwdata_i[4:0];
      if (wr & hit_c1 & ~err)
        ctrl_q[1] <= pwdata_i[4:0];
      if (wr & hit_dc & ~err)
        devcfg_q <= pwdata_i[4:0];
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;

  wire single = devcfg_q[`PPMC_D_SINGLE];
  wire [1:0] flag_clr = {2{wr & hit_fl & ~err}} & pwdata_i[1:0];

  // Per-port mode machines with their own timers.
  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      logic [31:0] req_q;
      logic [31:0] ack_q;
      logic [31:0] idle_q;
      logic [31:0] uvd_q;
      ppmc_pkg::ppmc_mode_t nxt;
      wire en_bit  = ctrl_q[p][`PPMC_C_PORT_EN] & ~(single & (p == 1));
      wire lps_dis = ctrl_q[p][`PPMC_C_LPS_DIS];
      wire ack_en  = ctrl_q[p][`PPMC_C_SLEEP_ACK];
      wire data    = rxdv[p] | transmit_enable_pin[p];
      wire req_exp = req_q >= N_REQ;
      wire ack_run = ack_q < N_ACK;
      wire wake    = (ctrl_q[p][`PPMC_C_FWD_REM] & wake_ev[p]) | wur_rx[p];
      wire go_sreq = (cmd_wr[p] & cmd == `PPMC_CMD_SLEEPREQ)
          | (ctrl_q[p][`PPMC_C_IDLE_PWD] & idle_q >= N_PD)
          | (~lps_dis & lps_rx[p] & lps_act[p]);
      wire back_n  = (cmd_wr[p] & cmd == `PPMC_CMD_NORMAL)
          | wake
          | (~ack_en & data);
      wire uv_tmp  = tmp_uv | io_uv;
      wire in_sl   = mode_q[p] == ppmc_pkg::PPMC_SLEEP;
      wire in_sb   = mode_q[p] == ppmc_pkg::PPMC_STANDBY;

      always_comb
      begin
        nxt = mode_q[p];
        // Priority order: power, IO undervoltage, reset, enable, temp/supply.
        if (!pwr_ok)
          nxt = ppmc_pkg::PPMC_STANDBY;
        else if (io_uv & ~in_sl)
          nxt = (in_sb & uvd_q >= N_UVD) ? ppmc_pkg::PPMC_SLEEP
                                         : ppmc_pkg::PPMC_STANDBY;
        else if (rst_pin & ~in_sl)
          nxt = ppmc_pkg::PPMC_STANDBY;
        else if (~en_pin | ~en_bit)
          nxt = (in_sl & en_pin) ? mode_q[p] : ppmc_pkg::PPMC_DISABLE;
        else if (uv_tmp & ~in_sl)
          nxt = (in_sb & uvd_q >= N_UVD) ? ppmc_pkg::PPMC_SLEEP
                                         : ppmc_pkg::PPMC_STANDBY;
        else
        begin
          case (mode_q[p])
            ppmc_pkg::PPMC_NORMAL:
              if (go_sreq)
                nxt = ppmc_pkg::PPMC_SLEEPREQ;
            ppmc_pkg::PPMC_STANDBY:
              if (cmd_wr[p] & cmd == `PPMC_CMD_NORMAL)
                nxt = ppmc_pkg::PPMC_NORMAL;
            ppmc_pkg::PPMC_SLEEPREQ:
              if (back_n & (~ack_en | ack_run))
                nxt = ppmc_pkg::PPMC_NORMAL;
              else if (~lps_dis & confirm[p] & (~ack_en | ~ack_run))
                nxt = ppmc_pkg::PPMC_SILENT;
              else if (lps_dis & req_exp)
                nxt = ppmc_pkg::PPMC_SLEEP;
              else if (~lps_dis & req_exp)
                nxt = ppmc_pkg::PPMC_NORMAL;
            ppmc_pkg::PPMC_SILENT:
              if (req_exp & chan[p])
                nxt = ppmc_pkg::PPMC_NORMAL;
              else if (~chan[p] & req_exp)
                nxt = ppmc_pkg::PPMC_SLEEP;
            ppmc_pkg::PPMC_SLEEP:
              if ((cmd_wr[p] & cmd == `PPMC_CMD_STANDBY) | rem_act[p])
                nxt = ppmc_pkg::PPMC_STANDBY;
            ppmc_pkg::PPMC_DISABLE:
              nxt = ppmc_pkg::PPMC_STANDBY;
            default:
              nxt = ppmc_pkg::PPMC_STANDBY;
          endcase
        end
      end

      wire chg = nxt != mode_q[p];
      always_ff @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          mode_q[p]  <= ppmc_pkg::PPMC_STANDBY;
          req_q      <= 32'h0;
          ack_q      <= 32'h0;
          idle_q     <= 32'h0;
          uvd_q      <= 32'h0;
          abort_q[p] <= 1'b0;
        end
        else
        begin
          mode_q[p] <= nxt;
          req_q  <= (chg & nxt != ppmc_pkg::PPMC_SILENT) ? 32'h0 :
                    req_exp ? req_q : req_q + 32'h1;
          ack_q  <= chg ? 32'h0 : ack_run ? ack_q + 32'h1 : ack_q;
          idle_q <= (data | mode_q[p] != ppmc_pkg::PPMC_NORMAL) ? 32'h0 :
                    (idle_q >= N_PD) ? idle_q : idle_q + 32'h1;
          uvd_q  <= (uv_tmp & in_sb & pwr_ok) ?
                    ((uvd_q >= N_UVD) ? uvd_q : uvd_q + 32'h1) : 32'h0;
          abort_q[p] <= (mode_q[p] == ppmc_pkg::PPMC_SILENT &
                         nxt == ppmc_pkg::PPMC_NORMAL) |
                        (abort_q[p] & ~flag_clr[p]);
        end
      end
    end
  endgenerate

  // Shared combiner and per-port pin controls.
  wire [1:0] p_sl, p_dis, p_sb, p_run;
  for (genvar q = 0; q < 2; q++)
  begin : g_cmb
    assign p_sl[q]  = mode_q[q] == ppmc_pkg::PPMC_SLEEP;
    assign p_dis[q] = ~ctrl_q[q][`PPMC_C_PORT_EN];
    assign p_sb[q]  = mode_q[q] == ppmc_pkg::PPMC_STANDBY;
    assign p_run[q] = mode_q[q] == ppmc_pkg::PPMC_NORMAL |
                      mode_q[q] == ppmc_pkg::PPMC_SLEEPREQ;
  end
  wire dev_sl = single ? p_sl[0]
                       : &(p_sl | p_dis);
  wire all_dis = &(p_dis | {single, 1'b0}) | ~en_pin;
  wire [1:0] clk_sel = devcfg_q[`PPMC_D_CLK_LSB +: 2];
  wire osc = dev_sl ? devcfg_q[`PPMC_D_CLK_HOLD] & ~clk_sel[1]
                    : |p_run & clk_sel != 2'h3;
  wire regulator_inhibit_out = dev_sl ? 1'b0 :
             all_dis ? devcfg_q[`PPMC_D_INH_DIS] : 1'b1;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rx_force_low_o          <= 2'h0;
      mii_drive_en_o          <= 2'h0;
      pcs_enable_o            <= 2'h0;
      activity_detect_en_o    <= 2'h0;
      sleep_request_code_o    <= 2'h0;
      regulator_inhibit_out_o <= 1'b1;
      osc_enable_o            <= 1'b0;
      device_sleep_o          <= 1'b0;
    end
    else
    begin
      rx_force_low_o          <= p_sb;
      mii_drive_en_o          <= p_run;
      pcs_enable_o            <= p_run;
      activity_detect_en_o    <= p_sb | p_sl;
      sleep_request_code_o[0] <= mode_q[0] == ppmc_pkg::PPMC_SLEEPREQ;
      sleep_request_code_o[1] <= mode_q[1] == ppmc_pkg::PPMC_SLEEPREQ;
      regulator_inhibit_out_o <= regulator_inhibit_out;
      osc_enable_o            <= osc;
      device_sleep_o          <= dev_sl;
    end
  end

endmodule

// File: hdl/ppmc_map.svh
`ifndef PPMC_MAP_SVH
`define PPMC_MAP_SVH

// Register byte offsets.
`define PPMC_CTRL0_OFF      12'h000
`define PPMC_CTRL1_OFF      12'h004
`define PPMC_CMD0_OFF       12'h008
`define PPMC_CMD1_OFF       12'h00C
`define PPMC_STAT_OFF       12'h010
`define PPMC_FLAG_OFF       12'h014
`define PPMC_DEVCFG_OFF     12'h018

// Per-port control field positions.
`define PPMC_C_PORT_EN      0
`define PPMC_C_IDLE_PWD     1
`define PPMC_C_LPS_DIS      2
`define PPMC_C_SLEEP_ACK    3
`define PPMC_C_FWD_REM      4
`define PPMC_CTRL_RST       5'h01

// Device configuration field positions.
`define PPMC_D_CLK_HOLD     0
`define PPMC_D_CLK_LSB      1
`define PPMC_D_INH_DIS      3
`define PPMC_D_SINGLE       4
`define PPMC_DEVCFG_RST     5'h08

// Power mode command codes.
`define PPMC_CMD_SLEEPREQ   4'hB
`define PPMC_CMD_NORMAL     4'h3
`define PPMC_CMD_STANDBY    4'hC

// Timing figures in microseconds and derived cycle counts at 100 MHz.
`define PPMC_CLK_MHZ        100
`define PPMC_T_REQ_US       16
`define PPMC_T_ACK_US       8
`define PPMC_T_PD_US        400
`define PPMC_T_UVD_US       200
`define PPMC_N_REQ          (`PPMC_T_REQ_US * `PPMC_CLK_MHZ)
`define PPMC_N_ACK          (`PPMC_T_ACK_US * `PPMC_CLK_MHZ)
`define PPMC_N_PD           (`PPMC_T_PD_US * `PPMC_CLK_MHZ)
`define PPMC_N_UVD          (`PPMC_T_UVD_US * `PPMC_CLK_MHZ)

`endif

// File: hdl/ppmc_pkg.sv
package ppmc_pkg;

  typedef enum logic [2:0] {
    PPMC_NORMAL   = 3'h0,
    PPMC_STANDBY  = 3'h1,
    PPMC_SLEEPREQ = 3'h2,
    PPMC_SILENT   = 3'h3,
    PPMC_SLEEP    = 3'h4,
    PPMC_DISABLE  = 3'h5
  } ppmc_mode_t;

endpackage

// File: dv/ppmc_top_sva.sv
`timescale 1ns/1ps
module ppmc_top_sva (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  input wire logic [1:0] rx_force_low_o,
  input wire logic [1:0] mii_drive_en_o,
  input wire logic [1:0] pcs_enable_o,
  input wire logic [1:0] activity_detect_en_o,
  input wire logic [1:0] sleep_request_code_o,
  input wire logic       regulator_inhibit_out_o,
  input wire logic       device_sleep_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_pcs_detect_excl: assert property (
    (pcs_enable_o & activity_detect_en_o) == 2'h0)
    else $error("pcs and detect both on");
  chk_standby_detect: assert property (
    (rx_force_low_o & ~activity_detect_en_o) == 2'h0)
    else $error("standby without detect");
  chk_req_pcs_on: assert property (
    sleep_request_code_o[0] |-> pcs_enable_o[0])
    else $error("sleep request without pcs");
  chk_sleep_inh_off: assert property (
    device_sleep_o |-> !regulator_inhibit_out_o)
    else $error("inhibit on in sleep");
  chk_sleep_quiet: assert property (
    device_sleep_o |-> pcs_enable_o == 2'h0 && mii_drive_en_o == 2'h0)
    else $error("port active in device sleep");
  chk_rst_inh_on: assert property (
    $fell(sys_rst_i) |-> regulator_inhibit_out_o)
    else $error("inhibit off after reset");
  chk_ready_timing: assert property (
    psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready late");
  chk_ready_pulse: assert property (
    pready_o |=> !pready_o)
    else $error("ready held");
  chk_err_ready: assert property (
    pslverr_o |-> pready_o)
    else $error("error without ready");
endmodule

// File: dv/ppmc_link_model.sv
`timescale 1ns/1ps
module ppmc_link_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] sleep_request_code_i,
  input  wire logic       confirm_en_i,
  input  wire logic       keep_busy_i,
  input  wire logic       send_sleep_i,
  output logic      [1:0] peer_confirm_o,
  output logic      [1:0] channel_active_o,
  output logic      [1:0] sleep_code_seen_o,
  output logic      [1:0] sleep_signalling_active_o
);
  logic [3:0] age_q [2] = '{4'h0, 4'h0};

  // A peer confirms only after the request has been heard for a while.
  always @(posedge clk_i)
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (!sleep_request_code_i[p])
        age_q[p] <= 4'h0;
      else if (age_q[p] != 4'hF)
        age_q[p] <= age_q[p] + 4'h1;
    end
  end

  assign peer_confirm_o[0] = confirm_en_i && age_q[0] > 4'h6;
  assign peer_confirm_o[1] = confirm_en_i && age_q[1] > 4'h6;
  assign channel_active_o = {2{keep_busy_i}} | sleep_request_code_i;
  assign sleep_code_seen_o = {2{send_sleep_i}};
  assign sleep_signalling_active_o = {2{send_sleep_i}};
endmodule

// File: dv/ppmc_top_bench.sv
`timescale 1ns/1ps
`include "ppmc_map.svh"
module phy_power_mode_controller_bench;
  localparam logic [2:0] NRM = ppmc_pkg::PPMC_NORMAL;
  localparam logic [2:0] SBY = ppmc_pkg::PPMC_STANDBY;
  localparam logic [2:0] SRQ = ppmc_pkg::PPMC_SLEEPREQ;
  localparam logic [2:0] SIL = ppmc_pkg::PPMC_SILENT;
  localparam logic [2:0] SLP = ppmc_pkg::PPMC_SLEEP;
  localparam logic [2:0] DIS = ppmc_pkg::PPMC_DISABLE;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic        io_uv_i = 1'b0;
  logic        temp_uv_i = 1'b0;
  logic        enable_pin_i = 1'b1;
  logic        reset_pin_n_i = 1'b1;
  logic [1:0]  wake_event_flag_i = 2'h0;
  logic [1:0]  remote_activity_i = 2'h0;
  logic [1:0]  pcs_receive_valid_i = 2'h0;
  logic [1:0]  transmit_enable_pin_i = 2'h0;
  logic [1:0]  wake_request_code_i = 2'h0;
  logic        cfm = 1'b0;
  logic        busy = 1'b0;
  logic        sleep_request_code = 1'b0;
  logic [31:0] rv;
  logic        re;
  int          n_fail = 0;
  int          checked = 0;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, regulator_inhibit_out_o;
  wire         osc_enable_o, device_sleep_o;
  wire  [1:0]  rx_force_low_o, mii_drive_en_o, pcs_enable_o;
  wire  [1:0]  activity_detect_en_o, sleep_request_code_o, peer_confirm_i;
  wire  [1:0]  channel_active_i, sleep_code_seen_i, sleep_signalling_active_i;

  ppmc_top #(.N_REQ(40), .N_ACK(20), .N_PD(60), .N_UVD(30)) i_dut (
    .clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .power_good_i(1'b1), .io_uv_i,
    .reset_pin_n_i, .enable_pin_i, .temp_uv_i, .pcs_receive_valid_i,
    .transmit_enable_pin_i, .sleep_code_seen_i, .sleep_signalling_active_i,
    .wake_request_code_i, .peer_confirm_i, .channel_active_i,
    .wake_event_flag_i, .remote_activity_i, .rx_force_low_o,
    .mii_drive_en_o, .pcs_enable_o, .activity_detect_en_o,
    .sleep_request_code_o, .regulator_inhibit_out_o, .osc_enable_o,
    .device_sleep_o);
  ppmc_link_model i_link (.clk_i, .sleep_request_code_i(sleep_request_code_o),
    .confirm_en_i(cfm), .keep_busy_i(busy), .send_sleep_i(sleep_request_code),
    .peer_confirm_o(peer_confirm_i), .channel_active_o(channel_active_i),
    .sleep_code_seen_o(sleep_code_seen_i),
    .sleep_signalling_active_o(sleep_signalling_active_i));

  initial forever #5 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    rv = prdata_o;
    re = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    chk(n < 20, 1'b1);
  endtask

  task automatic wait_mode(input int p, input logic [2:0] m);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `PPMC_STAT_OFF, 32'h0);
      n++;
    end
    while (rv[3*p +: 3] !== m && n < 150);
    chk(rv[3*p +: 3], m);
    repeat (3) @(posedge clk_i);
  endtask

  task automatic cmd(input logic [3:0] c, input logic [2:0] m);
    apb(1'b1, `PPMC_CMD0_OFF, {28'h0, c});
    wait_mode(0, m);
  endtask

  task automatic t_reset;
    chk(regulator_inhibit_out_o, 1'b1);
    apb(1'b0, `PPMC_STAT_OFF, 32'h0);
    chk(rv, 32'h9);
    apb(1'b0, `PPMC_DEVCFG_OFF, 32'h0);
    chk(rv, 32'h8);
    apb(1'b0, 12'h01C, 32'h0);
    chk(rv, 32'h0);
    chk(re, 1'b1);
    $display("reset test done");
  endtask

  task automatic t_cmd;
    apb(1'b1, `PPMC_CTRL0_OFF, 32'h5);
    apb(1'b1, `PPMC_CTRL1_OFF, 32'h0);
    cmd(4'h3, NRM);
    chk({pcs_enable_o[0], activity_detect_en_o[0]}, 2'h2);
    chk(osc_enable_o, 1'b1);
    cmd(4'hB, SRQ);
    chk(sleep_request_code_o[0], 1'b1);
    cmd(4'h3, NRM);
    cmd(4'hB, SRQ);
    apb(1'b0, `PPMC_STAT_OFF, 32'h0);
    chk(rv[2:0], SRQ);
    wait_mode(0, SLP);
    chk({device_sleep_o, regulator_inhibit_out_o, osc_enable_o}, 3'h4);
    apb(1'b1, `PPMC_CTRL0_OFF, 32'h1);
    chk(re, 1'b1);
    cmd(4'hC, SBY);
    chk({device_sleep_o, regulator_inhibit_out_o, rx_force_low_o[0]}, 3'h3);
    apb(1'b1, `PPMC_CTRL1_OFF, 32'h1);
    $display("command test done");
  endtask

  task automatic t_wake;
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, `PPMC_CTRL0_OFF, k == 3 ? 32'hD : 32'h5);
      cmd(4'h3, NRM);
      cmd(4'hB, SRQ);
      {pcs_receive_valid_i[0], transmit_enable_pin_i[0],
       wake_request_code_i[0]} <= k == 3 ? 3'h4 : 3'h1 << k;
      wait_mode(0, k == 3 ? SLP : NRM);
      {pcs_receive_valid_i[0], transmit_enable_pin_i[0],
       wake_request_code_i[0]} <= 3'h0;
    end
    cmd(4'hC, SBY);
    $display("wake test done");
  endtask

  task automatic t_silent;
    apb(1'b1, `PPMC_CTRL0_OFF, 32'h1);
    cfm <= 1'b1;
    busy <= 1'b1;
    cmd(4'h3, NRM);
    cmd(4'hB, SIL);
    wait_mode(0, NRM);
    apb(1'b0, `PPMC_FLAG_OFF, 32'h0);
    chk(rv[0], 1'b1);
    apb(1'b1, `PPMC_FLAG_OFF, 32'h1);
    apb(1'b0, `PPMC_FLAG_OFF, 32'h0);
    chk(rv[0], 1'b0);
    busy <= 1'b0;
    cmd(4'hB, SIL);
    wait_mode(0, SLP);
    cfm <= 1'b0;
    cmd(4'hC, SBY);
    $display("silent test done");
  endtask

  task automatic t_idle;
    apb(1'b1, `PPMC_CTRL0_OFF, 32'h3);
    cmd(4'h3, NRM);
    wait_mode(0, SRQ);
    apb(1'b1, `PPMC_CTRL0_OFF, 32'h1);
    cmd(4'h3, NRM);
    sleep_request_code <= 1'b1;
    wait_mode(0, SRQ);
    sleep_request_code <= 1'b0;
    cmd(4'h3, NRM);
    $display("idle test done");
  endtask

  task automatic t_remote;
    reset_pin_n_i <= 1'b0;
    wait_mode(0, SBY);
    reset_pin_n_i <= 1'b1;
    cmd(4'h3, NRM);
    apb(1'b1, `PPMC_CTRL0_OFF, 32'h15);
    apb(1'b1, `PPMC_DEVCFG_OFF, 32'h18);
    cmd(4'hB, SRQ);
    wake_event_flag_i <= 2'h1;
    wait_mode(0, NRM);
    wake_event_flag_i <= 2'h0;
    cmd(4'hB, SRQ);
    wait_mode(0, SLP);
    chk({device_sleep_o, regulator_inhibit_out_o}, 2'h2);
    remote_activity_i <= 2'h1;
    wait_mode(0, SBY);
    remote_activity_i <= 2'h0;
    apb(1'b1, `PPMC_DEVCFG_OFF, 32'h8);
    cmd(4'h3, NRM);
    $display("remote test done");
  endtask

  task automatic t_prio;
    enable_pin_i <= 1'b0;
    io_uv_i <= 1'b1;
    wait_mode(0, SBY);
    io_uv_i <= 1'b0;
    wait_mode(0, DIS);
    chk(regulator_inhibit_out_o, 1'b1);
    enable_pin_i <= 1'b1;
    wait_mode(0, SBY);
    temp_uv_i <= 1'b1;
    wait_mode(0, SLP);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk(regulator_inhibit_out_o, 1'b1);
    apb(1'b0, `PPMC_STAT_OFF, 32'h0);
    chk(rv, 32'h9);
    $display("priority test done");
  endtask

  task automatic final_report;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_cmd;
    t_wake;
    t_silent;
    t_idle;
    t_remote;
    t_prio;
    final_report;
  end

  initial
  begin
    repeat (30000) @(posedge clk_i);
    n_fail++;
    $display("[ERR] %0t timeout", $time);
    final_report;
  end
endmodule

bind ppmc_top ppmc_top_sva i_chk (.clk_i, .sys_rst_i, .psel_i, .penable_i,
  .pready_o, .pslverr_o, .rx_force_low_o, .mii_drive_en_o, .pcs_enable_o,
  .activity_detect_en_o, .sleep_request_code_o, .regulator_inhibit_out_o,
  .device_sleep_o);
